/* File: rtl/dtc_timer_top.sv */
// two timer/counters with a classic wishbone register slave
//
// Behaviour
// - mode 0: 5-bit prescaler feeds 8-bit high
// - mode 0 low bits 7:5 are undefined
// - mode 1: low carries into high, 16-bit
// - mode 2: overflow sets flag, reloads low
// - high byte writable anytime in reload mode
// - interrupt service clears the overflow flag
// - timer 0 mode 3: low byte own timer
// - mode 3 high: clk/6, timer 1 run, flag
// - timer 1 mode 3 halts, holds count
// - timer 1 fields: mode high nibble, ctrl
// - gate set lets interrupt pin gate counting
// - wrap to zero sets overflow flag, request
// - timer 1 overflow drives baud tick
// - timer counts once per six clocks
// - counter counts high-then-low pin samples
// - run does not clear count; preset stopped
// - timer 0 fields: mode low nibble, ctrl
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_timer_top
    import dtc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`DTC_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   t0_pin_i,
    input  wire logic                   t1_pin_i,
    input  wire logic                   ext_irq0_pin_i,
    input  wire logic                   ext_irq1_pin_i,
    input  wire logic                   irq0_ack_i,
    input  wire logic                   irq1_ack_i,
    output logic                        t0_irq_o,
    output logic                        t1_irq_o,
    output logic                        baud_tick_o
);
    logic [2:0]  div_cnt;
    logic        periph_tick;
    logic [7:0]  timer_mode_reg;
    logic        t0_run_bit;
    logic        t1_run_bit;
    logic        t0_overflow_flag;
    logic        t1_overflow_flag;
    logic        ext_irq0_flag;
    logic        ext_irq1_flag;
    logic        ext_irq0_type;
    logic        ext_irq1_type;
    logic [7:0]  timer_control_reg;
    dtc_mode_t   t0_mode;
    dtc_mode_t   t1_mode;
    logic        t0_gate_select;
    logic        t1_gate_select;
    logic        t0_counter_select;
    logic        t1_counter_select;
    logic        split0;
    logic        t0_en;
    logic        t1_en;
    logic        t0_ovf;
    logic        t0_hi_ovf;
    logic        t1_ovf;
    logic        t1_set;
    logic [7:0]  t0_count_low;
    logic [7:0]  t0_count_high;
    logic [7:0]  t1_count_low;
    logic [7:0]  t1_count_high;
    logic        bus_req;
    logic        bus_wr;
    logic        ctrl_wr;
    logic        mode_wr;
    logic [7:0]  wbyte;
    logic [31:0] rd_data;

    // peripheral cycle enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_cnt <= 3'h0;
        else if (periph_tick)
            div_cnt <= 3'h0;
        else
            div_cnt <= div_cnt + 3'h1;
    end
    assign periph_tick = (div_cnt == 3'(`DTC_DIV_LAST));

    // bus decode: one access per request, only byte lane 0 carries data
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // a write lands at the edge that completes the cycle, while ack is high
    assign bus_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign wbyte   = wb_dat_i[7:0];
    assign ctrl_wr = bus_wr & (wb_adr_i == `DTC_OFS_CTRL);
    assign mode_wr = bus_wr & (wb_adr_i == `DTC_OFS_MODE);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            timer_mode_reg <= `DTC_MODE_RST;
        else if (mode_wr)
            timer_mode_reg <= wbyte;
    end

    // mode fields
    assign t0_mode = dtc_mode_t'({timer_mode_reg[`DTC_MB_T0 + `DTC_MF_MHI],
                                  timer_mode_reg[`DTC_MB_T0 + `DTC_MF_MLO]});
    assign t1_mode = dtc_mode_t'({timer_mode_reg[`DTC_MB_T1 + `DTC_MF_MHI],
                                  timer_mode_reg[`DTC_MB_T1 + `DTC_MF_MLO]});
    assign t0_counter_select = timer_mode_reg[`DTC_MB_T0 + `DTC_MF_CSEL];
    assign t1_counter_select = timer_mode_reg[`DTC_MB_T1 + `DTC_MF_CSEL];
    assign t0_gate_select    = timer_mode_reg[`DTC_MB_T0 + `DTC_MF_GATE];
    assign t1_gate_select    = timer_mode_reg[`DTC_MB_T1 + `DTC_MF_GATE];
    assign split0            = (t0_mode == DTC_SPLIT);

    // run and gate
    assign t0_en = t0_run_bit & (~t0_gate_select | ext_irq0_pin_i);
    // while timer 0 is split its run bit is borrowed, so timer 1 runs freely
    // and software starts and stops it only through mode 3
    assign t1_en = (split0 | t1_run_bit)
                 & (~t1_gate_select | ext_irq1_pin_i);

    // control register bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            t0_run_bit    <= 1'b0;
            t1_run_bit    <= 1'b0;
            ext_irq0_type <= 1'b0;
            ext_irq1_type <= 1'b0;
            ext_irq0_flag <= 1'b0;
            ext_irq1_flag <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            t0_run_bit    <= wbyte[`DTC_CB_TR0];
            t1_run_bit    <= wbyte[`DTC_CB_TR1];
            ext_irq0_type <= wbyte[`DTC_CB_IT0];
            ext_irq1_type <= wbyte[`DTC_CB_IT1];
            ext_irq0_flag <= wbyte[`DTC_CB_IE0];
            ext_irq1_flag <= wbyte[`DTC_CB_IE1];
        end
    end

    // overflow flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            t0_overflow_flag <= 1'b0;
        else if (t0_ovf)
            t0_overflow_flag <= 1'b1;
        else if (irq0_ack_i)
            t0_overflow_flag <= 1'b0;
        else if (ctrl_wr)
            t0_overflow_flag <= wbyte[`DTC_CB_TF0];
    end

    assign t1_set = split0 ? t0_hi_ovf : t1_ovf;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            t1_overflow_flag <= 1'b0;
        else if (t1_set)
            t1_overflow_flag <= 1'b1;
        else if (irq1_ack_i)
            t1_overflow_flag <= 1'b0;
        else if (ctrl_wr)
            t1_overflow_flag <= wbyte[`DTC_CB_TF1];
    end

    assign t0_irq_o = t0_overflow_flag;
    assign t1_irq_o = t1_overflow_flag;

    // timer 1 overflows keep clocking the serial port even while split
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            baud_tick_o <= 1'b0;
        else
            baud_tick_o <= t1_ovf;
    end

    assign timer_control_reg = {t1_overflow_flag, t1_run_bit,
                                t0_overflow_flag, t0_run_bit,
                                ext_irq1_flag, ext_irq1_type,
                                ext_irq0_flag, ext_irq0_type};

    dtc_timer_unit #(
        .HAS_SPLIT (1'b1)
    ) u_t0 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (periph_tick),
        .pin_i      (t0_pin_i),
        .count_en_i (t0_en),
        .csel_i     (t0_counter_select),
        .mode_i     (t0_mode),
        .hi_run_i   (t1_run_bit),
        .wr_low_i   (bus_wr & (wb_adr_i == `DTC_OFS_T0L)),
        .wr_high_i  (bus_wr & (wb_adr_i == `DTC_OFS_T0H)),
        .wdata_i    (wbyte),
        .low_o      (t0_count_low),
        .high_o     (t0_count_high),
        .ovf_o      (t0_ovf),
        .ovf_hi_o   (t0_hi_ovf)
    );

    dtc_timer_unit #(
        .HAS_SPLIT (1'b0)
    ) u_t1 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (periph_tick),
        .pin_i      (t1_pin_i),
        .count_en_i (t1_en),
        .csel_i     (t1_counter_select),
        .mode_i     (t1_mode),
        .hi_run_i   (1'b0),
        .wr_low_i   (bus_wr & (wb_adr_i == `DTC_OFS_T1L)),
        .wr_high_i  (bus_wr & (wb_adr_i == `DTC_OFS_T1H)),
        .wdata_i    (wbyte),
        .low_o      (t1_count_low),
        .high_o     (t1_count_high),
        .ovf_o      (t1_ovf),
        .ovf_hi_o   ()
    );

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_data = 32'h0;
        case (wb_adr_i)
            `DTC_OFS_CTRL: rd_data[7:0] = timer_control_reg;
            `DTC_OFS_MODE: rd_data[7:0] = timer_mode_reg;
            `DTC_OFS_T0L:  rd_data[7:0] = t0_count_low;
            `DTC_OFS_T0H:  rd_data[7:0] = t0_count_high;
            `DTC_OFS_T1L:  rd_data[7:0] = t1_count_low;
            `DTC_OFS_T1H:  rd_data[7:0] = t1_count_high;
            default:       rd_data = 32'h0;
        endcase
    end

    // registered answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
                wb_dat_o <= rd_data;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_tick_gap;
        !periph_tick [*5] ##1 periph_tick;
    endsequence
    sequence s_flag_up;
        t0_overflow_flag && t0_irq_o;
    endsequence

    a_tick_period: assert property (periph_tick |=> s_tick_gap)
        else $error("peripheral tick not every six clocks");
    a_flag_on_wrap: assert property (t0_ovf |=> s_flag_up)
        else $error("overflow did not raise flag");
    a_service_clear: assert property (irq0_ack_i && !t0_ovf && !ctrl_wr
        |=> !t0_overflow_flag) else $error("service did not clear flag");
    a_split_flag: assert property (split0 && t0_hi_ovf |=> t1_overflow_flag)
        else $error("split high byte did not set timer 1 flag");
    a_gate_block: assert property (!t0_en && !bus_wr |=> $stable(t0_count_low))
        else $error("timer 0 counted while stopped");
    a_baud_tick: assert property (t1_ovf && !split0 |=> baud_tick_o && t1_overflow_flag)
        else $error("timer 1 overflow lost");
endmodule : dtc_timer_top

/* File: rtl/dtc_defs.svh */
// register offsets, field positions, reset values and timing counts of the timer block
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_ADDR_W      8
`define DTC_OFS_CTRL    8'h00
`define DTC_OFS_MODE    8'h04
`define DTC_OFS_T0L     8'h08
`define DTC_OFS_T0H     8'h0c
`define DTC_OFS_T1L     8'h10
`define DTC_OFS_T1H     8'h14
`define DTC_CB_IT0      0
`define DTC_CB_IE0      1
`define DTC_CB_IT1      2
`define DTC_CB_IE1      3
`define DTC_CB_TR0      4
`define DTC_CB_TF0      5
`define DTC_CB_TR1      6
`define DTC_CB_TF1      7
`define DTC_MB_T0       0
`define DTC_MB_T1       4
`define DTC_MF_MLO      0
`define DTC_MF_MHI      1
`define DTC_MF_CSEL     2
`define DTC_MF_GATE     3
`define DTC_CTRL_RST    8'h00
`define DTC_MODE_RST    8'h00
`define DTC_COUNT_RST   8'h00
`define DTC_PERIPH_CLKS 6
`define DTC_DIV_LAST    (`DTC_PERIPH_CLKS - 1)
`define DTC_PRESC_TOP   5'h1f
`define DTC_BYTE_TOP    8'hff
`endif

/* File: rtl/dtc_pkg.sv */
// types shared by the timer block
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE13,
        DTC_MODE16,
        DTC_RELOAD8,
        DTC_SPLIT
    } dtc_mode_t;
endpackage : dtc_pkg

/* File: rtl/dtc_timer_unit.sv */
// one timer/counter channel: count bytes, mode logic and overflow detection
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_timer_unit
    import dtc_pkg::*;
#(
    parameter bit HAS_SPLIT = 1'b0
)(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       pin_i,
    input  wire logic       count_en_i,
    input  wire logic       csel_i,
    input  wire dtc_mode_t  mode_i,
    input  wire logic       hi_run_i,
    input  wire logic       wr_low_i,
    input  wire logic       wr_high_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] low_o,
    output logic      [7:0] high_o,
    output logic            ovf_o,
    output logic            ovf_hi_o
);
    logic       pin_smp;
    logic       fall;
    logic       inc;
    logic       hi_inc;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] next_low;
    logic [7:0] next_high;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_smp <= 1'b0;
        else if (tick_i)
            pin_smp <= pin_i;
    end
    // a high sample followed by a low one counts once
    assign fall   = tick_i & pin_smp & ~pin_i;
    assign inc    = count_en_i & (csel_i ? fall : tick_i);
    assign hi_inc = HAS_SPLIT & (mode_i == DTC_SPLIT) & tick_i & hi_run_i;

    always_comb
    begin
        next_low  = low;
        next_high = high;
        ovf_o     = 1'b0;
        ovf_hi_o  = 1'b0;
        case (mode_i)
            DTC_MODE13:
            begin
                // bits 7:5 just hold; software must not rely on them
                if (inc)
                begin
                    next_low[4:0] = low[4:0] + 5'h01;
                    if (low[4:0] == `DTC_PRESC_TOP)
                    begin
                        next_high = high + 8'h01;
                        ovf_o     = (high == `DTC_BYTE_TOP);
                    end
                end
            end
            DTC_MODE16:
            begin
                if (inc)
                begin
                    next_low = low + 8'h01;
                    if (low == `DTC_BYTE_TOP)
                    begin
                        next_high = high + 8'h01;
                        ovf_o     = (high == `DTC_BYTE_TOP);
                    end
                end
            end
            DTC_RELOAD8:
            begin
                if (inc && (low == `DTC_BYTE_TOP))
                begin
                    next_low = high;
                    ovf_o    = 1'b1;
                end
                else if (inc)
                    next_low = low + 8'h01;
            end
            DTC_SPLIT:
            begin
                // without the split feature this mode only holds the count
                if (HAS_SPLIT && inc)
                begin
                    next_low = low + 8'h01;
                    ovf_o    = (low == `DTC_BYTE_TOP);
                end
                if (hi_inc)
                begin
                    next_high = high + 8'h01;
                    ovf_hi_o  = (high == `DTC_BYTE_TOP);
                end
            end
            default:
            begin
                next_low = low;
            end
        endcase
        if (wr_low_i)
            next_low = wdata_i;
        if (wr_high_i)
            next_high = wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low  <= `DTC_COUNT_RST;
            high <= `DTC_COUNT_RST;
        end
        else
        begin
            low  <= next_low;
            high <= next_high;
        end
    end
    assign low_o  = low;
    assign high_o = high;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reload_value: assert property ((mode_i == DTC_RELOAD8) && ovf_o && !wr_low_i
        |=> low == $past(high)) else $error("reload value wrong");
    a_carry_high: assert property ((mode_i == DTC_MODE16) && inc && (low == 8'hff)
        && !wr_high_i |=> high == $past(high) + 8'h01) else $error("no carry");
    a_prescale_hold: assert property ((mode_i == DTC_MODE13) && (low[4:0] != 5'h1f)
        && !wr_high_i |=> $stable(high)) else $error("high moved early");
    a_halt_hold: assert property (!HAS_SPLIT && (mode_i == DTC_SPLIT) && !wr_low_i
        && !wr_high_i |=> $stable(low) && $stable(high))
        else $error("halted count moved");
endmodule : dtc_timer_unit

/* File: tb/dtc_pin_model.sv */
// partner model: source of falling edges on an external count pin
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [7:0] edges_i,
    output logic            pin_o,
    output logic            busy_o
);
    // each level lasts two peripheral cycles, so every level is sampled at least once
    localparam int HALF = 12;
    int         cnt;
    logic [7:0] left;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_o  <= 1'b1;
            busy_o <= 1'b0;
            cnt    <= 0;
            left   <= 8'h00;
        end
        else if (go_i && !busy_o)
        begin
            left   <= edges_i;
            busy_o <= (edges_i != 8'h00);
            cnt    <= 0;
        end
        else if (busy_o && cnt == HALF - 1)
        begin
            cnt   <= 0;
            pin_o <= ~pin_o;
            if (!pin_o)
            begin
                left   <= left - 8'h01;
                busy_o <= (left != 8'h01);
            end
        end
        else if (busy_o)
        begin
            cnt <= cnt + 1;
        end
    end
endmodule : dtc_pin_model

/* File: tb/tb_top.sv */
// self-checking bench for the two timer/counters behind the wishbone slave
`timescale 1ns/1ps
`include "dtc_defs.svh"
module tb_top;
    import dtc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        t0_pin;
    logic        ext_irq0_pin = 1'b1;
    logic        ext_irq1_pin = 1'b0;
    logic        irq0_ack = 1'b0;
    logic        irq1_ack = 1'b0;
    logic        t0_irq_o;
    logic        t1_irq_o;
    logic        baud_tick_o;
    logic        pin_go = 1'b0;
    logic [7:0]  pin_edges = 8'h00;
    logic        pin_busy;
    int          failures = 0;
    int          tests_run = 0;

    always #20 clk_i = ~clk_i;

    dtc_timer_top u_dtc_timer_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .t0_pin_i(t0_pin), .t1_pin_i(t0_pin),
        .ext_irq0_pin_i(ext_irq0_pin), .ext_irq1_pin_i(ext_irq1_pin),
        .irq0_ack_i(irq0_ack), .irq1_ack_i(irq1_ack), .t0_irq_o(t0_irq_o),
        .t1_irq_o(t1_irq_o), .baud_tick_o(baud_tick_o));

    dtc_pin_model u_dtc_pin_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(pin_go), .edges_i(pin_edges),
        .pin_o(t0_pin), .busy_o(pin_busy));

    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_byte

    task automatic chk_span(input string name, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_span

    // holds the request until ack is sampled high, then releases it
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                           output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20)
            chk_byte("bus ack", 8'h01, 8'h00);
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [7:0] r;
        wb_xfer(1'b1, adr, wd, r);
    endtask : wr

    // counts edges until the chosen output is seen high: 0 t0 flag, 1 t1 flag, 2 baud
    task automatic wait_out(input int s, input int limit, inout int n);
        logic v;
        do
        begin
            @(posedge clk_i);
            n++;
            v = (s == 0) ? t0_irq_o : (s == 1) ? t1_irq_o : baud_tick_o;
        end while (v !== 1'b1 && n < limit);
    endtask : wait_out

    task automatic t_reset;
        logic [7:0] r;
        logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
        foreach (ofs[i])
        begin
            wb_xfer(1'b0, ofs[i], 8'h00, r);
            chk_byte("reset read", `DTC_COUNT_RST, r);
        end
        wr(8'h18, 8'ha5);
        wb_xfer(1'b0, 8'h18, 8'h00, r);
        chk_byte("unmapped read", 8'h00, r);
    endtask : t_reset

    task automatic t_mode0;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h00);
        wr(`DTC_OFS_T0H, 8'hfe);
        wr(`DTC_OFS_T0L, 8'h1f);
        wr(`DTC_OFS_CTRL, 8'h10);
        wait_out(0, 300, n);
        chk_span("mode0 overflow delay", 194, 199, n);
        wr(`DTC_OFS_CTRL, 8'h00);
        wb_xfer(1'b0, `DTC_OFS_T0H, 8'h00, r);
        chk_byte("mode0 high after wrap", 8'h00, r);
    endtask : t_mode0

    task automatic t_mode1;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h01);
        wr(`DTC_OFS_T0H, 8'hff);
        wr(`DTC_OFS_T0L, 8'hfd);
        wr(`DTC_OFS_CTRL, 8'h10);
        wait_out(0, 100, n);
        chk_span("mode1 overflow delay", 14, 19, n);
        irq0_ack <= 1'b1;
        @(posedge clk_i);
        irq0_ack <= 1'b0;
        @(posedge clk_i);
        chk_byte("t0 flag after service", 8'h00, {7'h0, t0_irq_o});
        wr(`DTC_OFS_CTRL, 8'h00);
        wb_xfer(1'b0, `DTC_OFS_T0H, 8'h00, r);
        chk_byte("mode1 high after carry", 8'h00, r);
    endtask : t_mode1

    task automatic t_reload0;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h02);
        wr(`DTC_OFS_T0H, 8'hf8);
        wr(`DTC_OFS_T0L, 8'hf8);
        wr(`DTC_OFS_CTRL, 8'h10);
        wait_out(0, 100, n);
        n = 0;
        irq0_ack <= 1'b1;
        @(posedge clk_i);
        irq0_ack <= 1'b0;
        n = 1;
        wait_out(0, 100, n);
        chk_span("mode2 t0 period", 48, 48, n);
        wb_xfer(1'b0, `DTC_OFS_CTRL, 8'h00, r);
        chk_byte("t0 control bits", 8'h30, r);
        wb_xfer(1'b0, `DTC_OFS_T0H, 8'h00, r);
        chk_byte("reload source kept", 8'hf8, r);
        wr(`DTC_OFS_CTRL, 8'h00);
    endtask : t_reload0

    task automatic t_baud;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h20);
        wr(`DTC_OFS_T1H, 8'hf0);
        wr(`DTC_OFS_T1L, 8'hf0);
        wr(`DTC_OFS_CTRL, 8'h40);
        wait_out(2, 200, n);
        n = 0;
        wait_out(2, 200, n);
        chk_span("baud period", 96, 96, n);
        wb_xfer(1'b0, `DTC_OFS_CTRL, 8'h00, r);
        chk_byte("t1 control bits", 8'hc0, r);
        irq1_ack <= 1'b1;
        @(posedge clk_i);
        irq1_ack <= 1'b0;
        @(posedge clk_i);
        chk_byte("t1 flag after service", 8'h00, {7'h0, t1_irq_o});
        wr(`DTC_OFS_T1H, 8'he0);
        n = 0;
        wait_out(2, 200, n);
        n = 0;
        wait_out(2, 400, n);
        chk_span("baud period after reload write", 192, 192, n);
        wr(`DTC_OFS_CTRL, 8'h00);
    endtask : t_baud

    task automatic t_counter;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h55);
        wr(`DTC_OFS_T0L, 8'h00);
        wr(`DTC_OFS_T1L, 8'h00);
        wr(`DTC_OFS_CTRL, 8'h50);
        pin_edges <= 8'h05;
        pin_go    <= 1'b1;
        @(posedge clk_i);
        pin_go <= 1'b0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (pin_busy !== 1'b0 && n < 400);
        wr(`DTC_OFS_CTRL, 8'h00);
        wb_xfer(1'b0, `DTC_OFS_T0L, 8'h00, r);
        chk_byte("falling edges counted", 8'h05, r);
        wb_xfer(1'b0, `DTC_OFS_T1L, 8'h00, r);
        chk_byte("t1 falling edges counted", 8'h05, r);
    endtask : t_counter

    task automatic t_gate;
        logic [7:0] r;
        wr(`DTC_OFS_MODE, 8'h90);
        wr(`DTC_OFS_T1L, 8'h00);
        wr(`DTC_OFS_CTRL, 8'h40);
        repeat (60) @(posedge clk_i);
        wb_xfer(1'b0, `DTC_OFS_T1L, 8'h00, r);
        chk_byte("gated count held", 8'h00, r);
        ext_irq1_pin <= 1'b1;
        repeat (60) @(posedge clk_i);
        ext_irq1_pin <= 1'b0;
        wb_xfer(1'b0, `DTC_OFS_T1L, 8'h00, r);
        chk_byte("count while gate open", 8'h0a, r);
        wr(`DTC_OFS_CTRL, 8'h00);
    endtask : t_gate

    task automatic t_split;
        logic [7:0] r;
        int         n;
        n = 0;
        wr(`DTC_OFS_MODE, 8'h33);
        wr(`DTC_OFS_T0L, 8'hff);
        wr(`DTC_OFS_T0H, 8'hfc);
        wr(`DTC_OFS_T1L, 8'h40);
        wr(`DTC_OFS_CTRL, 8'h50);
        wait_out(0, 50, n);
        chk_span("split low overflow", 2, 7, n);
        wait_out(1, 80, n);
        chk_span("split high overflow", 20, 25, n);
        wb_xfer(1'b0, `DTC_OFS_T1L, 8'h00, r);
        chk_byte("t1 held in mode 3", 8'h40, r);
        wr(`DTC_OFS_CTRL, 8'h00);
        wr(`DTC_OFS_MODE, 8'h00);
    endtask : t_split

    initial
    begin
        #800000;
        failures++;
        $display("Error watchdog expected finish seen hang");
        give_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mode0();
        t_mode1();
        t_reload0();
        t_baud();
        t_counter();
        t_gate();
        t_split();
        give_verdict();
    end
endmodule : tb_top
